// File: design/ebac_defs.svh
// constants of the external bus acknowledge and wait control block
`ifndef EBAC_DEFS_SVH
`define EBAC_DEFS_SVH
`define EBAC_NUM_CS 6
`define EBAC_CS_EDGE 3'h5
`define EBAC_CS_ACK_PIN 3'h4
`define EBAC_WSC_EDGE 6'h3F
`define EBAC_WSC_LEVEL_MIN 6'h01
`define EBAC_CSN_LEVEL_MAX 4'h3
`define EBAC_IGNORE_BASE 3'h2
`define EBAC_TIMEOUT_CYC 1024
`define EBAC_TO_W 11
`endif

// File: design/ebac_pkg.sv
// types shared by the external bus acknowledge and wait control block
package ebac_pkg;
   typedef enum logic [1:0] {
      EBAC_IDLE,
      EBAC_ASSERT,
      EBAC_ACTIVE,
      EBAC_NEGATE
   } ebac_state_e;
   typedef enum logic [1:0] {
      EBAC_MODE_PLAIN,
      EBAC_MODE_EDGE,
      EBAC_MODE_LEVEL
   } ebac_mode_e;
endpackage : ebac_pkg

// File: design/ebac_sync.sv
// two-flop synchroniser for the acknowledge input
`timescale 1ns/10ps
module ebac_sync (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // level in and out
   input wire logic d,
   output logic q
);
   logic meta;
   logic next_meta;
   logic next_q;
   always_comb begin
      next_meta = d;
      next_q = meta;
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta <= 1'b1;
         q <= 1'b1;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule : ebac_sync

// File: design/ebac_top.sv
// external bus cycle control with transfer acknowledge and timeout
// Functional notes
// - Each accepted cycle drives the selected active-low chip-select output.
// - With acknowledge termination on, a cycle unended after 1024 clocks gives a bus error.
// - The acknowledge input works either by rising edge or by level after an ignore time.
// - Acknowledge is honoured only on asynchronous cycles, never with burst mode set.
// - Edge mode ends the cycle on a rising acknowledge edge inside the timeout window.
// - Edge mode exists only on chip select 5.
// - Edge mode needs wait count 0x3F, assert or negate delay of 1 or more, and ack_gen_enable.
// - A nonzero assert or negate delay gives a gap so a fresh edge can be seen between cycles.
// - Level mode ignores the acknowledge for 2 to 5 clocks set by ack_ignore_cycles.
// - After the ignore time a high acknowledge lets the cycle finish on its wait count.
// - A low acknowledge stalls the cycle until high, bounded by the 1024-clock timeout.
// - In level mode a low acknowledge after the ignore time pauses the cycle until it is high.
// - Level mode is not available on chip select 4, whose pin carries the acknowledge.
// - Level mode needs early_wait_bit, wait count above 1, negate delay below 3, no ack_gen.
`include "ebac_defs.svh"
`timescale 1ns/10ps
module ebac_top #(
   parameter int NUM_CS = `EBAC_NUM_CS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // cycle request and its chip-select settings
   input wire logic req_valid,
   input wire logic [2:0] req_cs,
   input wire logic req_burst_mode,
   input wire logic [5:0] wait_state_count,
   input wire logic [3:0] cs_assert_delay,
   input wire logic [3:0] cs_negate_delay,
   input wire logic early_wait_bit,
   input wire logic [1:0] ack_ignore_cycles,
   input wire logic ack_gen_enable,
   // external acknowledge
   input wire logic transfer_ack_input,
   // chip selects, active low
   output logic [NUM_CS-1:0] cs_n,
   // cycle status
   output logic busy,
   output logic done,
   output logic bus_error
);
   localparam int TO_LAST = `EBAC_TIMEOUT_CYC - 1;
   localparam logic [`EBAC_TO_W-1:0] TO_END = TO_LAST[`EBAC_TO_W-1:0];

   ebac_pkg::ebac_state_e st, next_st;
   ebac_pkg::ebac_mode_e mode, next_mode;
   logic [2:0] sel, next_sel;
   logic [5:0] wait_cnt, next_wait_cnt;
   logic [2:0] ign_cnt, next_ign_cnt;
   logic [3:0] dly_cnt, next_dly_cnt;
   logic [3:0] neg_dly, next_neg_dly;
   logic [`EBAC_TO_W-1:0] to_cnt, next_to_cnt;
   logic [NUM_CS-1:0] next_cs_n;
   logic next_busy, next_done, next_bus_error;
   logic ack_s, ack_d;
   logic ack_rise;
   logic edge_ok, level_ok, fin, timeout;

   ////////////////////////////////////////////////////////////////////
   // acknowledge synchronising and edge detect
   ebac_sync u_sync (
      .ref_clk(ref_clk),
      .srst(srst),
      .d(transfer_ack_input),
      .q(ack_s)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_d <= 1'b1;
      end else begin
         ack_d <= ack_s;
      end
   end

   assign ack_rise = ack_s & ~ack_d;

   ////////////////////////////////////////////////////////////////////
   // mode choice at request time
   always_comb begin
      edge_ok = !req_burst_mode && req_cs == `EBAC_CS_EDGE
         && wait_state_count == `EBAC_WSC_EDGE && ack_gen_enable
         && (cs_assert_delay != 4'h0 || cs_negate_delay != 4'h0);
      level_ok = !req_burst_mode && req_cs != `EBAC_CS_ACK_PIN
         && early_wait_bit && wait_state_count > `EBAC_WSC_LEVEL_MIN
         && cs_negate_delay < `EBAC_CSN_LEVEL_MAX && !ack_gen_enable;
   end

   ////////////////////////////////////////////////////////////////////
   // cycle sequencing
   always_comb begin
      next_st = st;
      next_mode = mode;
      next_sel = sel;
      next_wait_cnt = wait_cnt;
      next_ign_cnt = ign_cnt;
      next_dly_cnt = dly_cnt;
      next_neg_dly = neg_dly;
      next_to_cnt = to_cnt;
      next_cs_n = cs_n;
      next_done = 1'b0;
      next_bus_error = 1'b0;
      fin = 1'b0;
      timeout = 1'b0;
      unique case (st)
         ebac_pkg::EBAC_IDLE: begin
            if (req_valid) begin
               next_sel = req_cs;
               next_wait_cnt = wait_state_count;
               next_ign_cnt = {1'b0, ack_ignore_cycles} + `EBAC_IGNORE_BASE;
               next_neg_dly = cs_negate_delay;
               next_to_cnt = '0;
               if (edge_ok) begin
                  next_mode = ebac_pkg::EBAC_MODE_EDGE;
               end else if (level_ok) begin
                  next_mode = ebac_pkg::EBAC_MODE_LEVEL;
               end else begin
                  next_mode = ebac_pkg::EBAC_MODE_PLAIN;
               end
               if (cs_assert_delay != 4'h0) begin
                  next_dly_cnt = cs_assert_delay;
                  next_st = ebac_pkg::EBAC_ASSERT;
               end else begin
                  next_cs_n = ~(NUM_CS'(1) << req_cs);
                  next_st = ebac_pkg::EBAC_ACTIVE;
               end
            end
         end
         ebac_pkg::EBAC_ASSERT: begin
            next_to_cnt = to_cnt + 1'b1;
            next_dly_cnt = dly_cnt - 4'h1;
            if (dly_cnt == 4'h1) begin
               next_cs_n = ~(NUM_CS'(1) << sel);
               next_st = ebac_pkg::EBAC_ACTIVE;
            end
         end
         ebac_pkg::EBAC_ACTIVE: begin
            next_to_cnt = to_cnt + 1'b1;
            if (ign_cnt != 3'h0) begin
               next_ign_cnt = ign_cnt - 3'h1;
            end
            unique case (mode)
               ebac_pkg::EBAC_MODE_EDGE: begin
                  fin = ack_rise;
               end
               ebac_pkg::EBAC_MODE_LEVEL: begin
                  if (ign_cnt == 3'h0 && !ack_s) begin
                     fin = 1'b0;
                  end else begin
                     fin = ign_cnt == 3'h0 && wait_cnt == 6'h00;
                     if (wait_cnt != 6'h00) begin
                        next_wait_cnt = wait_cnt - 6'h01;
                     end
                  end
               end
               default: begin
                  fin = wait_cnt == 6'h00;
                  if (wait_cnt != 6'h00) begin
                     next_wait_cnt = wait_cnt - 6'h01;
                  end
               end
            endcase
            timeout = !fin && mode != ebac_pkg::EBAC_MODE_PLAIN
               && to_cnt == TO_END;
            if (fin || timeout) begin
               next_done = fin;
               next_bus_error = timeout;
               next_cs_n = '1;
               next_dly_cnt = neg_dly;
               next_st = (neg_dly != 4'h0) ? ebac_pkg::EBAC_NEGATE
                  : ebac_pkg::EBAC_IDLE;
            end
         end
         ebac_pkg::EBAC_NEGATE: begin
            next_dly_cnt = dly_cnt - 4'h1;
            if (dly_cnt == 4'h1) begin
               next_st = ebac_pkg::EBAC_IDLE;
            end
         end
      endcase
      next_busy = next_st != ebac_pkg::EBAC_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st <= ebac_pkg::EBAC_IDLE;
         mode <= ebac_pkg::EBAC_MODE_PLAIN;
         sel <= 3'h0;
         wait_cnt <= 6'h00;
         ign_cnt <= 3'h0;
         dly_cnt <= 4'h0;
         neg_dly <= 4'h0;
         to_cnt <= '0;
         cs_n <= '1;
         busy <= 1'b0;
         done <= 1'b0;
         bus_error <= 1'b0;
      end else begin
         st <= next_st;
         mode <= next_mode;
         sel <= next_sel;
         wait_cnt <= next_wait_cnt;
         ign_cnt <= next_ign_cnt;
         dly_cnt <= next_dly_cnt;
         neg_dly <= next_neg_dly;
         to_cnt <= next_to_cnt;
         cs_n <= next_cs_n;
         busy <= next_busy;
         done <= next_done;
         bus_error <= next_bus_error;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   property p_timeout;
      bus_error |-> $past(to_cnt) == TO_END && $past(mode) != ebac_pkg::EBAC_MODE_PLAIN;
   endproperty
   a_timeout: assert property (p_timeout) else $error("bus error not at timeout");

   property p_edge_end;
      done && $past(mode) == ebac_pkg::EBAC_MODE_EDGE |-> $past(ack_rise);
   endproperty
   a_edge_end: assert property (p_edge_end) else $error("edge cycle ended without edge");

   property p_level_stall;
      st == ebac_pkg::EBAC_ACTIVE && mode == ebac_pkg::EBAC_MODE_LEVEL && ign_cnt == 3'h0
         && !ack_s |=> !done;
   endproperty
   a_level_stall: assert property (p_level_stall) else $error("level cycle ended with ack low");

   property p_ignore;
      st == ebac_pkg::EBAC_IDLE && req_valid && level_ok && cs_assert_delay == 4'h0
         |=> !done [*2];
   endproperty
   a_ignore: assert property (p_ignore) else $error("level cycle ended inside ignore time");

   property p_edge_cs5;
      mode == ebac_pkg::EBAC_MODE_EDGE && busy |-> sel == `EBAC_CS_EDGE;
   endproperty
   a_edge_cs5: assert property (p_edge_cs5) else $error("edge mode off chip select 5");

   property p_level_cs4;
      mode == ebac_pkg::EBAC_MODE_LEVEL && busy |-> sel != `EBAC_CS_ACK_PIN;
   endproperty
   a_level_cs4: assert property (p_level_cs4) else $error("level mode on chip select 4");

   property p_cs_drive;
      st == ebac_pkg::EBAC_ACTIVE |-> cs_n == ~(NUM_CS'(1) << sel);
   endproperty
   a_cs_drive: assert property (p_cs_drive) else $error("chip select wrong while active");

   property p_gap;
      st == ebac_pkg::EBAC_ACTIVE && (fin || timeout) && neg_dly != 4'h0
         |=> cs_n == '1 && busy && st == ebac_pkg::EBAC_NEGATE;
   endproperty
   a_gap: assert property (p_gap) else $error("no negate gap after cycle");

   property p_burst;
      st == ebac_pkg::EBAC_IDLE && req_valid && req_burst_mode
         |=> mode == ebac_pkg::EBAC_MODE_PLAIN;
   endproperty
   a_burst: assert property (p_burst) else $error("ack mode on burst cycle");

   c_edge_done: cover property (done && $past(mode) == ebac_pkg::EBAC_MODE_EDGE);
   c_level_stall: cover property (mode == ebac_pkg::EBAC_MODE_LEVEL && st ==
      ebac_pkg::EBAC_ACTIVE && ign_cnt == 3'h0 && !ack_s ##[1:100] done);
   c_timeout: cover property (bus_error);
endmodule : ebac_top

// File: sim/ebac_ack_model.sv
// external device model that answers a cycle on the acknowledge input
`timescale 1ns/10ps
module ebac_ack_model (
   // clock
   input wire logic ref_clk,
   // chip selects watched, active low
   input wire logic [5:0] cs_n,
   // behaviour: 0 stays low, 1 rises after delay, 2 low for delay then high
   input wire logic [1:0] ack_mode,
   input wire logic [7:0] ack_delay,
   // acknowledge towards the device
   output logic ack
);
   logic [7:0] cnt;
   always_ff @(posedge ref_clk) begin
      if (&cs_n) begin
         cnt <= 8'h00;
         ack <= (ack_mode == 2'h2);
      end else begin
         cnt <= cnt + 8'h01;
         ack <= (ack_mode != 2'h0) && (cnt >= ack_delay);
      end
   end
endmodule : ebac_ack_model

// File: sim/ebac_top_tb_top.sv
// self-checking bench of the acknowledge and wait control block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module ebac_top_tb_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0, req_burst_mode = 1'b0, early_wait_bit = 1'b0, ack_gen_enable = 1'b0;
   logic [2:0] req_cs = 3'h0;
   logic [5:0] wait_state_count = 6'h00;
   logic [3:0] cs_assert_delay = 4'h0, cs_negate_delay = 4'h0;
   logic [1:0] ack_ignore_cycles = 2'h0, ack_mode = 2'h0;
   logic [7:0] ack_delay = 8'h00;
   logic ack, busy, done, bus_error;
   logic [5:0] cs_n;
   int num_errors = 0, total_checks = 0, cyc = 0;
   always #20 ref_clk = ~ref_clk;
   ebac_top dut_u (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid), .req_cs(req_cs),
      .req_burst_mode(req_burst_mode), .wait_state_count(wait_state_count),
      .cs_assert_delay(cs_assert_delay), .cs_negate_delay(cs_negate_delay),
      .early_wait_bit(early_wait_bit), .ack_ignore_cycles(ack_ignore_cycles),
      .ack_gen_enable(ack_gen_enable), .transfer_ack_input(ack), .cs_n(cs_n), .busy(busy),
      .done(done), .bus_error(bus_error));
   ebac_ack_model ext_u (.ref_clk(ref_clk), .cs_n(cs_n), .ack_mode(ack_mode),
      .ack_delay(ack_delay), .ack(ack));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 8000) begin
         num_errors++;
         end_of_test();
      end
   end
   // one cycle: settings, partner behaviour, expected ending and latency range
   task automatic run(input logic [2:0] cs, input logic bu, input logic [5:0] w,
         input logic [3:0] a, input logic [3:0] n, input logic ew, input logic [1:0] ig,
         input logic ag, input logic [1:0] am, input logic [7:0] ad, input logic err,
         input int lo, input int hi);
      int k;
      logic seen;
      @(posedge ref_clk);
      req_cs <= cs; req_burst_mode <= bu; wait_state_count <= w; cs_assert_delay <= a;
      cs_negate_delay <= n; early_wait_bit <= ew; ack_ignore_cycles <= ig;
      ack_gen_enable <= ag; ack_mode <= am; ack_delay <= ad; req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      k = 0;
      seen = 1'b0;
      while (k < 1100 && done !== 1'b1 && bus_error !== 1'b1) begin
         @(negedge ref_clk);
         if (cs_n === ~(6'h01 << cs)) seen = 1'b1;
         @(posedge ref_clk);
         #1;
         k++;
      end
      `CHK("bus_error", err, bus_error)
      `CHK("done", ~err, done)
      `CHK("latency", 1'b1, k >= lo && k <= hi)
      `CHK("chip select", 1'b1, seen)
      `CHK("cs_n after end", 6'h3F, cs_n)
      `CHK("busy in gap", n != 4'h0, busy)
      while (busy === 1'b1) @(posedge ref_clk);
   endtask : run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int w, a;
      void'($urandom(32'h162AE6D6));
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      run(3'h0, 0, 6'h00, 4'h0, 4'h0, 0, 2'h0, 0, 2'h0, 8'h00, 0, 1, 1);
      run(3'h5, 0, 6'h3F, 4'h1, 4'h0, 0, 2'h0, 1, 2'h1, 8'h0A, 0, 12, 20);
      run(3'h5, 0, 6'h3F, 4'h0, 4'h1, 0, 2'h0, 1, 2'h1, 8'h0A, 0, 11, 19);
      run(3'h5, 0, 6'h3F, 4'h0, 4'h1, 0, 2'h0, 1, 2'h1, 8'h03, 0, 4, 12);
      run(3'h5, 0, 6'h3F, 4'h1, 4'h0, 0, 2'h0, 1, 2'h0, 8'h00, 1, 1024, 1026);
      run(3'h4, 0, 6'h3F, 4'h1, 4'h0, 0, 2'h0, 1, 2'h0, 8'h00, 0, 65, 65);
      run(3'h5, 1, 6'h3F, 4'h1, 4'h0, 0, 2'h0, 1, 2'h0, 8'h00, 0, 65, 65);
      for (int i = 0; i < 4; i++) begin
         run(3'h2, 0, 6'h02, 4'h0, 4'h0, 1, i[1:0], 0, 2'h2, 8'h00, 0, i + 3, i + 8);
      end
      run(3'h2, 0, 6'h02, 4'h0, 4'h2, 1, 2'h1, 0, 2'h2, 8'h1E, 0, 30, 40);
      run(3'h1, 0, 6'h02, 4'h0, 4'h0, 1, 2'h0, 0, 2'h0, 8'h00, 1, 1024, 1026);
      run(3'h4, 0, 6'h02, 4'h0, 4'h0, 1, 2'h0, 0, 2'h2, 8'h1E, 0, 3, 3);
      run(3'h2, 0, 6'h01, 4'h0, 4'h0, 1, 2'h0, 0, 2'h2, 8'h1E, 0, 2, 2);
      run(3'h3, 0, 6'h02, 4'h0, 4'h3, 1, 2'h0, 0, 2'h2, 8'h1E, 0, 3, 3);
      for (int i = 0; i < 20; i++) begin
         w = $urandom_range(20);
         a = $urandom_range(3);
         run(3'($urandom_range(5)), 0, 6'(w), 4'(a), 4'($urandom_range(3)), 0, 2'h0, 0,
            2'h0, 8'h00, 0, a + w + 1, a + w + 1);
      end
      end_of_test();
   end
endmodule : ebac_top_tb_top
